// File: src/txpcf_defines.svh
// constants for the transmit phase compensation fifo
`ifndef TXPCF_DEFINES_SVH
`define TXPCF_DEFINES_SVH

// ----------------------------------------------------------------
// datapath sizes
// ----------------------------------------------------------------
`define TXPCF_WORD_W      20
`define TXPCF_DEPTH       4
`define TXPCF_BYTE_W      8

// ----------------------------------------------------------------
// width select codes and the masks they apply
// ----------------------------------------------------------------
`define TXPCF_WSEL_8      2'h0
`define TXPCF_WSEL_10     2'h1
`define TXPCF_WSEL_16     2'h2
`define TXPCF_WSEL_20     2'h3
`define TXPCF_MASK_8      20'h000ff
`define TXPCF_MASK_10     20'h003ff
`define TXPCF_MASK_16     20'h0ffff
`define TXPCF_MASK_20     20'hfffff

// ----------------------------------------------------------------
// write source select codes
// ----------------------------------------------------------------
`define TXPCF_SRC_USER    2'h0
`define TXPCF_SRC_PIPE    2'h1
`define TXPCF_SRC_HIP     2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TXPCF_WORD_RST    20'h00000
`define TXPCF_WSEL_RST    2'h0
`define TXPCF_SRC_RST     2'h0

`endif

// File: src/txpcf_fifo.sv
// parameterised valid/ready fifo with registered read data
`timescale 1ns/1ps

module txpcf_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // write side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic             bypass,
   // read side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    cnt_reg;
   logic [CW-1:0]    cnt_next;
   logic [WIDTH-1:0] out_data_reg;
   logic             out_valid_reg;
   logic             out_valid_next;
   logic             in_ready_reg;
   logic             push;
   logic             pop;
   logic [CW:0]      occ_next;

   // the output register counts toward the depth so total storage stays at DEPTH words
   assign push           = in_valid && in_ready_reg && !bypass;
   assign pop            = (cnt_reg != '0) && (!out_valid_reg || out_ready);
   assign cnt_next       = CW'(cnt_reg + CW'(push) - CW'(pop));
   assign out_valid_next = pop || (out_valid_reg && !out_ready);
   assign occ_next       = (CW + 1)'(cnt_next) + (CW + 1)'(out_valid_next);

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         cnt_reg       <= '0;
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
         in_ready_reg  <= 1'b0;
      end else begin
         wr_ptr_reg    <= push ? AW'((wr_ptr_reg + 1) % DEPTH) : wr_ptr_reg;
         rd_ptr_reg    <= pop ? AW'((rd_ptr_reg + 1) % DEPTH) : rd_ptr_reg;
         cnt_reg       <= cnt_next;
         out_valid_reg <= out_valid_next;
         out_data_reg  <= pop ? mem[rd_ptr_reg] : out_data_reg;
         in_ready_reg  <= bypass || (occ_next < (CW + 1)'(DEPTH));
      end
   end

   assign in_ready  = in_ready_reg;
   assign out_data  = out_data_reg;
   assign out_valid = out_valid_reg;

endmodule

// File: src/txpcf_pkg.sv
// types shared by the transmit phase compensation fifo
`include "txpcf_defines.svh"

package txpcf_pkg;

   typedef logic [`TXPCF_WORD_W-1:0] txpcf_word_t;
   typedef logic [1:0]               txpcf_wsel_t;
   typedef logic [1:0]               txpcf_src_t;

   // output stage: idle or holding a word for the coding path
   typedef enum logic [1:0] {
      TXPCF_OUT_IDLE = 2'b01,
      TXPCF_OUT_FULL = 2'b10
   } txpcf_out_state_t;

endpackage

// File: src/txpcf_top.sv
// transmit phase compensation fifo between fabric writers and the transmit coding path
`timescale 1ns/1ps

// Summary of operation
// - fabric-side words are buffered and handed to the parallel-clock coding path
// - storage holds five 20-bit words: four in the fifo and one in the output stage
// - normal mode: a written word reaches the output three to four cycles later
// - fixed-latency mode: one registered stage, one cycle of latency
// - write width is 8, 10, 16 or 20 bits, fixed by configuration
// - output carries the full word; narrowing to 8 or 10 happens downstream
// - fifo sits in the path for user logic, pipe wrapper or pcie core
// - optional bit-flip reverses bit order inside each byte before storage
module txpcf_top
   import txpcf_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // configuration
   input  wire txpcf_wsel_t width_sel,
   input  wire txpcf_src_t  src_sel,
   input  wire logic        fixed_lat_en,
   input  wire logic        bit_flip_en,
   // user fabric writer
   input  wire txpcf_word_t user_data,
   input  wire logic        user_valid,
   // pipe wrapper writer
   input  wire txpcf_word_t pipe_data,
   input  wire logic        pipe_valid,
   // pcie core writer
   input  wire txpcf_word_t hip_data,
   input  wire logic        hip_valid,
   // write back-pressure, shared by all writers
   output logic             wr_ready,
   // coding path side
   output txpcf_word_t      tx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready
);

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   txpcf_wsel_t      wsel_reg;
   txpcf_src_t       src_reg;
   logic             fixed_reg;
   logic             flip_reg;

   // ----------------------------------------------------------------
   // datapath signals
   // ----------------------------------------------------------------
   txpcf_word_t      src_data;
   logic             src_valid;
   txpcf_word_t      width_mask;
   txpcf_word_t      masked_data;
   txpcf_word_t      flipped_data;
   txpcf_word_t      flip10_data;
   txpcf_word_t      wr_word;
   logic             fifo_in_ready;
   txpcf_word_t      fifo_out_data;
   logic             fifo_out_valid;
   logic             fifo_out_ready;
   txpcf_out_state_t out_state_reg;
   txpcf_out_state_t out_state_next;
   txpcf_word_t      tx_data_reg;
   txpcf_word_t      tx_data_next;
   logic             out_free;
   logic             fixed_take;
   logic             norm_take;

   function automatic logic [`TXPCF_BYTE_W-1:0] rev_byte(input logic [`TXPCF_BYTE_W-1:0] b);
      logic [`TXPCF_BYTE_W-1:0] r;
      r = '0;
      for (int i = 0; i < `TXPCF_BYTE_W; i++) begin
         r[i] = b[`TXPCF_BYTE_W-1-i];
      end
      return r;
   endfunction

   // config is static in use; sampling it keeps the decode off the writers' timing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wsel_reg  <= `TXPCF_WSEL_RST;
         src_reg   <= `TXPCF_SRC_RST;
         fixed_reg <= 1'b0;
         flip_reg  <= 1'b0;
      end else begin
         wsel_reg  <= width_sel;
         src_reg   <= src_sel;
         fixed_reg <= fixed_lat_en;
         flip_reg  <= bit_flip_en;
      end
   end

   // ----------------------------------------------------------------
   // write source selection
   // ----------------------------------------------------------------
   // unused source codes select nothing, so no stray writes reach the fifo
   assign src_data  = (src_reg == `TXPCF_SRC_PIPE) ? pipe_data :
                      (src_reg == `TXPCF_SRC_HIP)  ? hip_data  :
                      (src_reg == `TXPCF_SRC_USER) ? user_data : `TXPCF_WORD_RST;
   assign src_valid = (src_reg == `TXPCF_SRC_PIPE) ? pipe_valid :
                      (src_reg == `TXPCF_SRC_HIP)  ? hip_valid  :
                      (src_reg == `TXPCF_SRC_USER) && user_valid;

   // ----------------------------------------------------------------
   // width masking and byte-level bit flip
   // ----------------------------------------------------------------
   assign width_mask  = (wsel_reg == `TXPCF_WSEL_8)  ? `TXPCF_MASK_8  :
                        (wsel_reg == `TXPCF_WSEL_10) ? `TXPCF_MASK_10 :
                        (wsel_reg == `TXPCF_WSEL_16) ? `TXPCF_MASK_16 : `TXPCF_MASK_20;
   assign masked_data = src_data & width_mask;

   // bits 19:16 never form a full byte and pass unflipped
   assign flipped_data = {masked_data[19:16],
                          rev_byte(masked_data[15:8]),
                          rev_byte(masked_data[7:0])};
   // a 10-bit word holds one full byte; its top two bits pass unflipped instead of being lost
   assign flip10_data  = {masked_data[19:8], rev_byte(masked_data[7:0])};
   assign wr_word      = !flip_reg                    ? masked_data :
                         (wsel_reg == `TXPCF_WSEL_10) ? flip10_data : (flipped_data & width_mask);

   // ----------------------------------------------------------------
   // four-word buffer
   // ----------------------------------------------------------------
   // in fixed-latency mode the buffer is bypassed and reports ready every cycle
   txpcf_fifo #(
      .WIDTH (`TXPCF_WORD_W),
      .DEPTH (`TXPCF_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_data   (wr_word),
      .in_valid  (src_valid),
      .in_ready  (fifo_in_ready),
      .bypass    (fixed_reg),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready)
   );

   assign wr_ready = fifo_in_ready;

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   // fixed mode assumes the coding path takes a word every parallel cycle
   assign out_free       = (out_state_reg == TXPCF_OUT_IDLE) || tx_ready;
   assign fixed_take     = fixed_reg && src_valid;
   assign norm_take      = !fixed_reg && fifo_out_valid && out_free;
   assign fifo_out_ready = !fixed_reg && out_free;

   always_comb begin
      out_state_next = out_state_reg;
      tx_data_next   = tx_data_reg;
      case (out_state_reg)
         TXPCF_OUT_IDLE: begin
            if (fixed_take) begin
               out_state_next = TXPCF_OUT_FULL;
               tx_data_next   = wr_word;
            end else if (norm_take) begin
               out_state_next = TXPCF_OUT_FULL;
               tx_data_next   = fifo_out_data;
            end
         end
         TXPCF_OUT_FULL: begin
            if (fixed_take) begin
               tx_data_next = wr_word;
            end else if (norm_take) begin
               tx_data_next = fifo_out_data;
            end else if (fixed_reg || tx_ready) begin
               out_state_next = TXPCF_OUT_IDLE;
            end
         end
         default: begin
            out_state_next = TXPCF_OUT_IDLE;
            tx_data_next   = `TXPCF_WORD_RST;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_state_reg <= TXPCF_OUT_IDLE;
         tx_data_reg   <= `TXPCF_WORD_RST;
         tx_valid      <= 1'b0;
      end else begin
         out_state_reg <= out_state_next;
         tx_data_reg   <= tx_data_next;
         tx_valid      <= (out_state_next == TXPCF_OUT_FULL);
      end
   end

   assign tx_data = tx_data_reg;

endmodule

// File: verification/testbench.sv
// self-checking bench for the phase compensation fifo
`timescale 1ns/1ps
`include "txpcf_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module testbench
   import txpcf_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        fixed_lat_en = 1'b0;
   logic        bit_flip_en = 1'b0;
   logic        tx_ready = 1'b0;
   txpcf_wsel_t width_sel = `TXPCF_WSEL_20;
   txpcf_src_t  src_sel = `TXPCF_SRC_USER;
   txpcf_word_t ud, pd, hd, tx_data, w;
   logic        uv, pv, hv, wr_ready, tx_valid;
   int          n_errors = 0, n_checks = 0, n;
   txpcf_word_t masks [4] = '{`TXPCF_MASK_8, `TXPCF_MASK_10, `TXPCF_MASK_16, `TXPCF_MASK_20};

   initial forever #4 ref_clk = ~ref_clk;

   txpcf_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .width_sel(width_sel), .src_sel(src_sel),
      .fixed_lat_en(fixed_lat_en), .bit_flip_en(bit_flip_en), .user_data(ud), .user_valid(uv),
      .pipe_data(pd), .pipe_valid(pv), .hip_data(hd), .hip_valid(hv), .wr_ready(wr_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   txpcf_writer U (.ref_clk(ref_clk), .wr_ready(wr_ready), .no_wait(fixed_lat_en), .data(ud), .valid(uv));
   txpcf_writer P (.ref_clk(ref_clk), .wr_ready(wr_ready), .no_wait(fixed_lat_en), .data(pd), .valid(pv));
   txpcf_writer H (.ref_clk(ref_clk), .wr_ready(wr_ready), .no_wait(fixed_lat_en), .data(hd), .valid(hv));

   task automatic results();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic timeout();
      n_errors++;
      results();
   endtask

   task automatic stop();
      fork U.stop(); P.stop(); H.stop(); join
   endtask

   // n counts falling edges from the one before the take, so a latency of L edges gives n = L + 1
   task automatic get(input int stall);
      n = 0;
      repeat (stall) @(negedge ref_clk) tx_ready = 1'b0;
      do begin
         @(negedge ref_clk);
         tx_ready = 1'b1;
         n++;
      end while (tx_valid !== 1'b1 && n < 50);
      if (tx_valid !== 1'b1) timeout();
      w = tx_data;
   endtask

   task automatic one(input txpcf_src_t s, input txpcf_word_t d);
      fork
         begin
            case (s)
               `TXPCF_SRC_PIPE: P.send(d);
               `TXPCF_SRC_HIP: H.send(d);
               default: U.send(d);
            endcase
            stop();
         end
         get(0);
      join
   endtask

   task automatic cfg(input txpcf_wsel_t ws, input txpcf_src_t s, input logic fl);
      @(negedge ref_clk);
      width_sel = ws;
      src_sel = s;
      bit_flip_en = fl;
      repeat (2) @(negedge ref_clk);
   endtask

   task automatic t_reset();
      repeat (8) @(negedge ref_clk);
      `CHK("ready in reset", 1'b0, wr_ready)
      `CHK("valid in reset", 1'b0, tx_valid)
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK("ready after reset", 1'b1, wr_ready)
      $display("reset test done");
   endtask

   task automatic t_width();
      for (int i = 0; i < 4; i++) begin
         cfg(txpcf_wsel_t'(i), txpcf_src_t'(i % 3), 1'b0);
         one(src_sel, 20'hfffff ^ 20'(i));
         `CHK("masked word", (20'hfffff ^ 20'(i)) & masks[i], w)
         `CHK("latency", 1'b1, 1'(n == 4 || n == 5))
      end
      cfg(`TXPCF_WSEL_16, `TXPCF_SRC_USER, 1'b1);
      one(`TXPCF_SRC_USER, 20'hfbcad);
      `CHK("flipped word", 20'h03db5, w)
      cfg(`TXPCF_WSEL_10, `TXPCF_SRC_USER, 1'b1);
      one(`TXPCF_SRC_USER, 20'hfffad);
      `CHK("flipped 10-bit word", 20'h003b5, w)
      cfg(`TXPCF_WSEL_20, 2'h3, 1'b0);
      U.send(20'h00055);
      U.stop();
      repeat (6) begin
         @(negedge ref_clk);
         `CHK("no writer selected", 1'b0, tx_valid)
      end
      cfg(`TXPCF_WSEL_20, `TXPCF_SRC_USER, 1'b0);
      $display("width test done");
   endtask

   task automatic t_fill();
      int s0;
      s0 = U.sent;
      @(negedge ref_clk) tx_ready = 1'b0;
      fork
         begin
            for (int k = 0; k < 6; k++) U.send(20'h00010 + 20'(k));
            U.stop();
         end
      join_none
      repeat (20) @(negedge ref_clk);
      `CHK("refused when full", 1'b0, wr_ready)
      `CHK("words held", 1'b1, 1'(U.sent - s0 >= 4 && U.sent - s0 <= 5))
      for (int k = 0; k < 6; k++) begin
         get(k % 2);
         `CHK("drain order", 20'h00010 + 20'(k), w)
      end
      $display("fill test done");
   endtask

   // words in flight when reset strikes must not come out afterwards
   task automatic t_midrst();
      @(negedge ref_clk) tx_ready = 1'b0;
      U.send(20'h00077);
      U.send(20'h00088);
      U.stop();
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b0;
      @(negedge ref_clk);
      `CHK("valid in mid reset", 1'b0, tx_valid)
      `CHK("ready in mid reset", 1'b0, wr_ready)
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK("empty after mid reset", 1'b0, tx_valid)
      `CHK("ready after mid reset", 1'b1, wr_ready)
      one(`TXPCF_SRC_USER, 20'h00099);
      `CHK("fresh word after reset", 20'h00099, w)
      `CHK("fresh latency", 1'b1, 1'(n == 4 || n == 5))
      $display("mid reset test done");
   endtask

   task automatic t_fixed();
      @(negedge ref_clk) fixed_lat_en = 1'b1;
      repeat (2) @(negedge ref_clk);
      fork
         begin
            U.send(20'h000a1);
            U.send(20'h000b2);
            U.stop();
         end
         begin
            get(0);
            `CHK("fixed latency", 1'b1, 1'(n == 2))
            `CHK("fixed word", 20'h000a1, w)
            get(0);
            `CHK("fixed next", 20'h000b2, w)
         end
      join
      @(negedge ref_clk);
      `CHK("one cycle each", 1'b0, tx_valid)
      fixed_lat_en = 1'b0;
      $display("fixed test done");
   endtask

   initial begin
      t_reset();
      t_width();
      t_fill();
      t_midrst();
      t_fixed();
      results();
   end
endmodule

// File: verification/txpcf_top_sva.sv
// port checks for the transmit phase compensation fifo
`timescale 1ns/1ps
`include "txpcf_defines.svh"

module txpcf_top_sva
   import txpcf_pkg::*;
(
   // every top port, observed only
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire txpcf_wsel_t width_sel,
   input wire txpcf_src_t  src_sel,
   input wire logic        fixed_lat_en,
   input wire logic        bit_flip_en,
   input wire txpcf_word_t user_data,
   input wire logic        user_valid,
   input wire txpcf_word_t pipe_data,
   input wire logic        pipe_valid,
   input wire txpcf_word_t hip_data,
   input wire logic        hip_valid,
   input wire logic        wr_ready,
   input wire txpcf_word_t tx_data,
   input wire logic        tx_valid,
   input wire logic        tx_ready
);
   // ----
   // words in flight; fixed mode keeps no count
   // ----
   logic [3:0]  cnt_reg;
   logic [3:0]  cnt_next;
   logic        sel_v;
   logic        take;
   txpcf_word_t mask;
   assign sel_v = src_sel == `TXPCF_SRC_USER ? user_valid : src_sel == `TXPCF_SRC_PIPE ? pipe_valid :
                  src_sel == `TXPCF_SRC_HIP ? hip_valid : 1'b0;
   assign take = sel_v && wr_ready && !fixed_lat_en;
   assign cnt_next = fixed_lat_en ? 4'h0 : cnt_reg + 4'(take) - 4'(tx_valid && tx_ready);
   assign mask = width_sel == `TXPCF_WSEL_8 ? `TXPCF_MASK_8 : width_sel == `TXPCF_WSEL_10 ? `TXPCF_MASK_10 :
                 width_sel == `TXPCF_WSEL_16 ? `TXPCF_MASK_16 : `TXPCF_MASK_20;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cnt_reg <= 4'h0;
      else cnt_reg <= cnt_next;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_quiet; !tx_valid ##1 !tx_valid; endsequence

   hold_out_a:
      assert property (!fixed_lat_en && tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("stall lost");
   depth_a:
      assert property (cnt_reg <= 4'h5) else $error("too many words held");
   lat_norm_a:
      assert property (take && cnt_reg == 4'h0 && !tx_valid |=> s_quiet ##[1:2] tx_valid) else $error("bad latency");
   fix_one_a:
      assert property (fixed_lat_en && $past(fixed_lat_en) && sel_v |=> tx_valid) else $error("fixed word missing");
   fix_gap_a:
      assert property (fixed_lat_en && $past(fixed_lat_en) && !sel_v |=> !tx_valid) else $error("fixed word extra");
   width_mask_a:
      assert property (tx_valid |-> (tx_data & ~mask) == 20'h00000) else $error("bits above width");
   ready_idle_a:
      assert property (!fixed_lat_en && !$past(fixed_lat_en, 2) && $past(rst_n) && cnt_reg == 4'h0 &&
                       $past(cnt_reg) == 4'h0 |-> wr_ready) else $error("empty but not ready");
   no_spur_a:
      assert property (!fixed_lat_en && tx_valid |-> cnt_reg != 4'h0) else $error("output without write");
endmodule

bind txpcf_top txpcf_top_sva chk (.ref_clk(ref_clk), .rst_n(rst_n), .width_sel(width_sel), .src_sel(src_sel),
   .fixed_lat_en(fixed_lat_en), .bit_flip_en(bit_flip_en), .user_data(user_data), .user_valid(user_valid),
   .pipe_data(pipe_data), .pipe_valid(pipe_valid), .hip_data(hip_data), .hip_valid(hip_valid),
   .wr_ready(wr_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

// File: verification/txpcf_writer.sv
// writer model for the fabric side of the fifo
`timescale 1ns/1ps

module txpcf_writer
   import txpcf_pkg::*;
(
   // clock and flow control
   input  wire logic   ref_clk,
   input  wire logic   wr_ready,
   input  wire logic   no_wait,
   // word to the fifo
   output txpcf_word_t data,
   output logic        valid
);
   int sent = 0;

   initial begin
      data = 20'h00000;
      valid = 1'b0;
   end

   // word held until the edge that takes it; ready is read at the falling edge, where it has settled
   task automatic send(input txpcf_word_t w);
      int n;
      n = 0;
      @(negedge ref_clk);
      data = w;
      valid = 1'b1;
      while (wr_ready !== 1'b1 && !no_wait && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      if (wr_ready !== 1'b1 && !no_wait) testbench.timeout();
      @(posedge ref_clk);
      sent++;
   endtask

   // released lines show the inverse so a stale word never matches
   task automatic stop();
      @(negedge ref_clk);
      valid = 1'b0;
      data = ~data;
   endtask
endmodule
